// ### hdl/logic_cell.sv
// logic_cell.sv: configurable logic cell with a wishbone register file
// assumes one clock clk_i, synchronous reset rst_i, classic wishbone
`timescale 1ns/1ps
`default_nettype none
`include "logic_cell_params.svh"

module logic_cell #(
    parameter int NUM_INPUTS = `LC_NUM_INPUTS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] async_in_i,
    input wire logic [3:0] periph_i,
    output logic cell_out_o,
    output logic pin_out_o,
    output logic pin_oe_o
);

    // the select fields are four bits wide, so sixteen sources exactly
    if (NUM_INPUTS != `LC_NUM_INPUTS) begin : g_bad_inputs
        $error("logic_cell serves exactly sixteen inputs");
    end

    // three-stage synchroniser for pins and foreign clocks
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] async_filt_reg;
    logic [7:0] async_filt_next;

    // a change is taken only once stages two and three agree
    always_comb begin
        async_filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg)
                        | ((sync2_reg ^ sync3_reg) & async_filt_reg);
    end

    // first stage feeds only the second one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            sync3_reg <= 8'h00;
            async_filt_reg <= 8'h00;
        end else begin
            sync1_reg <= async_in_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            async_filt_reg <= async_filt_next;
        end
    end

    // register file
    logic [7:0] g2_sel_reg;
    logic [7:0] g2_sel_next;
    logic [15:0] line_sel_reg;
    logic [15:0] line_sel_next;
    logic [23:0] gsel_reg;
    logic [23:0] gsel_next;
    logic [11:0] ctrl_reg;
    logic [11:0] ctrl_next;
    logic [3:0] sw_bits_reg;
    logic [3:0] sw_bits_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    logic [3:0] line_val;
    logic [3:0] gate_val;
    logic out_reg;

    // byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] lanes);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (lanes[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    logic req;
    logic wr_stb;
    logic [31:0] merged;
    logic [31:0] cur_word;

    assign req = cyc_i & stb_i & ~ack_reg;
    assign wr_stb = req & we_i;

    // current value of the addressed word; unmapped reads give zero
    always_comb begin
        unique case (adr_i)
            `LC_OFS_G2SEL: cur_word = {24'h000000, g2_sel_reg};
            `LC_OFS_LINESEL: cur_word = {16'h0000, line_sel_reg};
            `LC_OFS_GSEL: cur_word = {8'h00, gsel_reg};
            `LC_OFS_CTRL: cur_word = {20'h00000, ctrl_reg};
            `LC_OFS_SWBITS: cur_word = {28'h0000000, sw_bits_reg};
            `LC_OFS_STATUS: cur_word = {20'h00000, gate_val,
                                        line_val, 3'h0, out_reg};
            default: cur_word = 32'h00000000;
        endcase
    end

    assign merged = lane_merge(cur_word, dat_i, sel_i);

    // one wait state: ack rises the cycle after the request is seen
    always_comb begin
        g2_sel_next = g2_sel_reg;
        line_sel_next = line_sel_reg;
        gsel_next = gsel_reg;
        ctrl_next = ctrl_reg;
        sw_bits_next = sw_bits_reg;
        ack_next = req;
        rdata_next = rdata_reg;
        if (req) begin
            rdata_next = we_i ? 32'h00000000 : cur_word;
        end
        if (wr_stb) begin
            unique case (adr_i)
                `LC_OFS_G2SEL: g2_sel_next = merged[7:0];
                `LC_OFS_LINESEL: line_sel_next = merged[15:0];
                `LC_OFS_GSEL: gsel_next = merged[23:0];
                `LC_OFS_CTRL: ctrl_next = merged[11:0];
                `LC_OFS_SWBITS: sw_bits_next = merged[3:0];
                default: ;
            endcase
        end
    end

    // gate 2 select keeps its contents across resets on purpose
    always_ff @(posedge clk_i) begin
        g2_sel_reg <= g2_sel_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_sel_reg <= `LC_RST_LINESEL;
            gsel_reg <= `LC_RST_GSEL;
            ctrl_reg <= `LC_RST_CTRL;
            sw_bits_reg <= `LC_RST_SWBITS;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            line_sel_reg <= line_sel_next;
            gsel_reg <= gsel_next;
            ctrl_reg <= ctrl_next;
            sw_bits_reg <= sw_bits_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = rdata_reg;

    // input pool: synced pins and clocks, peripherals, software bits
    logic [15:0] src_pool;
    assign src_pool = {sw_bits_reg, periph_i, async_filt_reg};

    // each data line picks one of sixteen sources
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            line_val[k] = src_pool[line_sel_reg[4*k +: 4]];
        end
    end

    // a gate ORs every enabled true and inverted term, zero if none;
    // odd select bit takes the line true, even bit takes it inverted
    function automatic logic gate_or(input logic [7:0] gsel,
                                     input logic [3:0] lines);
        logic acc;
        acc = 1'b0;
        for (int k = 0; k < 4; k++) begin
            acc = acc | (gsel[2*k+1] & lines[k])
                      | (gsel[2*k] & ~lines[k]);
        end
        return acc;
    endfunction

    logic [3:0] line_true;
    logic [3:0] line_inv;
    logic gate_two_raw;
    assign line_true = line_val;
    assign line_inv = ~line_val;

    // gate 2 terms spelled out per select bit
    assign gate_two_raw =
        (g2_sel_reg[7] & line_true[3]) | (g2_sel_reg[6] & line_inv[3])
      | (g2_sel_reg[5] & line_true[2]) | (g2_sel_reg[4] & line_inv[2])
      | (g2_sel_reg[3] & line_true[1]) | (g2_sel_reg[2] & line_inv[1])
      | (g2_sel_reg[1] & line_true[0]) | (g2_sel_reg[0] & line_inv[0]);

    // four gates, each with its own output polarity
    logic [3:0] gate_pol;
    assign gate_pol = ctrl_reg[`LC_CTRL_GPOL_MSB:`LC_CTRL_GPOL_LSB];
    always_comb begin
        gate_val[0] = gate_or(gsel_reg[7:0], line_val) ^ gate_pol[0];
        gate_val[1] = gate_two_raw ^ gate_pol[1];
        gate_val[2] = gate_or(gsel_reg[15:8], line_val) ^ gate_pol[2];
        gate_val[3] = gate_or(gsel_reg[23:16], line_val) ^ gate_pol[3];
    end

    // function core; gate 1 is the clock or enable of the storage modes, a set input in the SR latch
    logic_cell_pkg::mode_t mode;
    logic cell_en;
    logic out_pol;
    logic q_reg;
    logic q_next;
    logic g1_prev_reg;
    logic g1_rise;
    logic func_val;
    logic out_next;

    assign mode = logic_cell_pkg::mode_t'(
        ctrl_reg[`LC_CTRL_MODE_MSB:`LC_CTRL_MODE_LSB]);
    assign cell_en = ctrl_reg[`LC_CTRL_EN_BIT];
    assign out_pol = ctrl_reg[`LC_CTRL_POL_BIT];
    assign g1_rise = gate_val[0] & ~g1_prev_reg;

    // storage element; reset input always overrides set and data
    always_comb begin
        q_next = q_reg;
        unique case (mode)
            logic_cell_pkg::MODE_SR_LATCH: begin
                if (gate_val[2] | gate_val[3]) begin
                    q_next = 1'b0;
                end else if (gate_val[0] | gate_val[1]) begin
                    q_next = 1'b1;
                end
            end
            logic_cell_pkg::MODE_DFF_SR: begin
                if (gate_val[2]) begin
                    q_next = 1'b0;
                end else if (gate_val[3]) begin
                    q_next = 1'b1;
                end else if (g1_rise) begin
                    q_next = gate_val[1];
                end
            end
            logic_cell_pkg::MODE_JK_R: begin
                if (gate_val[2]) begin
                    q_next = 1'b0;
                end else if (g1_rise) begin
                    q_next = (gate_val[1] & ~q_reg)
                           | (~gate_val[3] & q_reg);
                end
            end
            logic_cell_pkg::MODE_DLATCH_SR: begin
                if (gate_val[2]) begin
                    q_next = 1'b0;
                end else if (gate_val[3]) begin
                    q_next = 1'b1;
                end else if (gate_val[0]) begin
                    q_next = gate_val[1];
                end
            end
            default: ;
        endcase
    end

    // selected function before the output polarity
    always_comb begin
        unique case (mode)
            logic_cell_pkg::MODE_AND_OR:
                func_val = (gate_val[0] & gate_val[1])
                         | (gate_val[2] & gate_val[3]);
            logic_cell_pkg::MODE_OR_XOR:
                func_val = (gate_val[0] | gate_val[1])
                         ^ (gate_val[2] | gate_val[3]);
            logic_cell_pkg::MODE_AND4:
                func_val = &gate_val;
            logic_cell_pkg::MODE_AND_OR_INV:
                func_val = ~((gate_val[0] & gate_val[1])
                           | (gate_val[2] & gate_val[3]));
            default: func_val = q_next;
        endcase
        out_next = cell_en & (func_val ^ out_pol);
    end

    // disabled cell holds its output low; the storage keeps following its gates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= 1'b0;
            g1_prev_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
            g1_prev_reg <= gate_val[0];
            out_reg <= out_next;
        end
    end

    // same registered result to peripherals and to the pin
    assign cell_out_o = out_reg;
    assign pin_out_o = out_reg;
    assign pin_oe_o = ctrl_reg[`LC_CTRL_OE_BIT];

endmodule // logic_cell

`default_nettype wire

// ### hdl/logic_cell_params.svh
// logic_cell_params.svh: register offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef LOGIC_CELL_PARAMS_SVH
`define LOGIC_CELL_PARAMS_SVH

// register byte offsets, all word aligned
`define LC_OFS_G2SEL 8'h00
`define LC_OFS_LINESEL 8'h04
`define LC_OFS_GSEL 8'h08
`define LC_OFS_CTRL 8'h0C
`define LC_OFS_SWBITS 8'h10
`define LC_OFS_STATUS 8'h14

// control register fields
`define LC_CTRL_MODE_LSB 0
`define LC_CTRL_MODE_MSB 2
`define LC_CTRL_POL_BIT 4
`define LC_CTRL_OE_BIT 6
`define LC_CTRL_EN_BIT 7
`define LC_CTRL_GPOL_LSB 8
`define LC_CTRL_GPOL_MSB 11

// status register fields
`define LC_STAT_OUT_BIT 0
`define LC_STAT_LINE_LSB 4
`define LC_STAT_LINE_MSB 7
`define LC_STAT_GATE_LSB 8
`define LC_STAT_GATE_MSB 11

// reset values of the resettable registers
`define LC_RST_LINESEL 16'h0000
`define LC_RST_GSEL 24'h000000
`define LC_RST_CTRL 12'h000
`define LC_RST_SWBITS 4'h0

// input source counts
`define LC_NUM_INPUTS 16
`define LC_NUM_ASYNC 8
`define LC_NUM_PERIPH 4
`define LC_NUM_SW 4

`endif

// ### hdl/logic_cell_pkg.sv
// logic_cell_pkg.sv: types shared by the logic cell
// assumes nothing beyond a systemverilog compiler
package logic_cell_pkg;

    // selectable single-output functions of the cell
    typedef enum logic [2:0] {
        MODE_AND_OR = 3'h0,
        MODE_OR_XOR = 3'h1,
        MODE_AND4 = 3'h2,
        MODE_SR_LATCH = 3'h3,
        MODE_DFF_SR = 3'h4,
        MODE_JK_R = 3'h5,
        MODE_DLATCH_SR = 3'h6,
        MODE_AND_OR_INV = 3'h7
    } mode_t;

endpackage

// ### tb/logic_cell_properties.sv
// logic_cell_properties.sv: port checker for the logic cell
// assumes a classic wishbone slave with one wait state and registered ack
`timescale 1ns/1ps
`default_nettype none
module logic_cell_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [7:0] async_in_i,
    input wire logic [3:0] periph_i,
    input wire logic cell_out_o,
    input wire logic pin_out_o,
    input wire logic pin_oe_o
);
    logic take;
    logic [7:0] g2_shadow_reg;
    logic g2_known_reg = 1'b0;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a request is taken while the slave is not answering
    assign take = cyc_i && stb_i && !ack_o;

    // shadow of the gate 2 select; kept over rst_i like the register
    always_ff @(posedge clk_i) begin
        if (take && we_i && adr_i == 8'h00 && sel_i[0]) begin
            g2_shadow_reg <= dat_i[7:0];
            g2_known_reg <= 1'b1;
        end
    end

    ack_timing_a: assert property (take |=> ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(take))
        else $error("ack without request");
    reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && dat_o == 32'h0 && !pin_oe_o && !cell_out_o)
        else $error("outputs not cleared by reset");
    pin_copy_a: assert property (cell_out_o == pin_out_o)
        else $error("pin differs from internal output");
    g2_readback_a: assert property (take && !we_i && adr_i == 8'h00
        && g2_known_reg |=> dat_o[7:0] == g2_shadow_reg)
        else $error("gate 2 select read differs from write");
    g2_upper_a: assert property (take && !we_i && adr_i == 8'h00
        |=> dat_o[31:8] == 24'h0)
        else $error("unused select bits not zero");
    unmapped_zero_a: assert property (take && !we_i && adr_i > 8'h14
        |=> dat_o == 32'h0)
        else $error("unmapped read not zero");

    g2_write_c: cover property (take && we_i && adr_i == 8'h00);
    g2_read_c: cover property (take && !we_i && adr_i == 8'h00);
    pin_drive_c: cover property (pin_oe_o && pin_out_o);
endmodule // logic_cell_properties

bind logic_cell logic_cell_properties i_logic_cell_properties (.clk_i,
    .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .async_in_i, .periph_i, .cell_out_o, .pin_out_o, .pin_oe_o);
`default_nettype wire

// ### tb/tb_logic_cell.sv
// tb_logic_cell.sv: register-level test of the logic cell
// assumes a 125 MHz clock and the one-wait-state wishbone slave
`timescale 1ns/1ps
`default_nettype none
module tb_logic_cell;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic [7:0] async_in_i = 8'h00;
    logic [3:0] periph_i = 4'h0;
    logic ack_o;
    logic cell_out_o;
    logic pin_out_o;
    logic pin_oe_o;
    logic e;
    logic [31:0] g2_exp;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    // storage steps: mode, software bits, expected output
    logic [11:0] steps [26] = '{12'h311, 12'h301, 12'h340, 12'h300,
        12'h350, 12'h440, 12'h420, 12'h431, 12'h401, 12'h410, 12'h481,
        12'h540, 12'h520, 12'h531, 12'h501, 12'h511, 12'h581, 12'h590,
        12'h500, 12'h5B1, 12'h640, 12'h631, 12'h610, 12'h600, 12'h620,
        12'h681};

    logic_cell i_logic_cell (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .async_in_i, .periph_i, .cell_out_o,
        .pin_out_o, .pin_oe_o);

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; read data lands in rd at the ack edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hF;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // combinational functions with g1..g4 in g[0]..g[3]
    function automatic logic fn(int m, logic [3:0] g);
        case (m % 8)
            0: return (g[0] & g[1]) | (g[2] & g[3]);
            1: return (g[0] | g[1]) ^ (g[2] | g[3]);
            2: return &g;
            default: return ~((g[0] & g[1]) | (g[2] & g[3]));
        endcase
    endfunction

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b1, 8'h00, 32'hFFFFFFA5);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h000000A5);
        // a second reset must leave the select register alone
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h000000A5);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        // line 1 from a peripheral, line 2 from a synchronised pin
        bus(1'b1, 8'h04, 32'h0000FE08);
        for (int v = 0; v < 2; v++) begin
            periph_i <= {3'h0, v[0]};
            async_in_i <= {7'h00, v[0]};
            repeat (8) @(posedge clk_i);
            bus(1'b0, 8'h14, 32'h0);
            check(rd & 32'h30, v[0] ? 32'h30 : 32'h0);
        end
        // lines from software bits; each select bit alone, then none
        bus(1'b1, 8'h04, 32'h0000FEDC);
        for (int s = 0; s < 9; s++) begin
            bus(1'b1, 8'h00, (s == 8) ? 32'h0 : 32'h1 << s);
            for (int v = 0; v < 16; v++) begin
                bus(1'b1, 8'h10, 32'(v));
                repeat (4) @(posedge clk_i);
                bus(1'b0, 8'h14, 32'h0);
                e = (s < 8) && (v[s / 2] == s[0]);
                g2_exp = e ? 32'h200 : 32'h0;
                check(rd & 32'hF0, 32'(v) << 4);
                check(rd & 32'h200, g2_exp);
            end
        end
        // an empty gate 2 reads as one once its polarity is inverted
        bus(1'b1, 8'h0C, 32'h200);
        bus(1'b0, 8'h14, 32'h0);
        check(rd & 32'hF00, 32'h200);
        // gate k follows line k; combinational modes with both polarities
        bus(1'b1, 8'h08, 32'h00802002);
        bus(1'b1, 8'h00, 32'h08);
        for (int m = 0; m < 16; m++) begin
            if (m % 8 inside {[3:6]}) continue;
            bus(1'b1, 8'h0C, 32'hC0 | 32'(m % 8) | (32'(m / 8) << 4));
            for (int v = 0; v < 16; v++) begin
                bus(1'b1, 8'h10, 32'(v));
                repeat (4) @(posedge clk_i);
                e = fn(m, v[3:0]) ^ m[3];
                check(32'(cell_out_o), 32'(e));
                check({30'h0, pin_oe_o, pin_out_o}, {30'h0, 1'b1, e});
            end
        end
        // storage modes, switching mode only where the table does
        foreach (steps[i]) begin
            if (i == 0 || steps[i][11:8] != steps[i - 1][11:8]) begin
                bus(1'b1, 8'h0C, {24'h0, 2'h3, 3'h0, steps[i][10:8]});
            end
            bus(1'b1, 8'h10, {28'h0, steps[i][7:4]});
            repeat (4) @(posedge clk_i);
            check(32'(cell_out_o), 32'(steps[i][0]));
        end
        bus(1'b1, 8'h0C, 32'h0);
        repeat (4) @(posedge clk_i);
        check({30'h0, pin_oe_o, cell_out_o}, 32'h0);
        end_of_test();
    end
endmodule // tb_logic_cell
`default_nettype wire
